//--- hw/rtc_calendar.sv
// BCD time and calendar keeper with timed wake-up, checksum view and flash write counter.
// Assumes a register port in the clk_i domain and event/checksum inputs from on-chip logic.
`timescale 1ns/1ps
`include "rtc_cfg.svh"

module rtc_calendar #(
  parameter logic [31:0] MINUTE_CYCLES    = 32'(`RTC_MINUTE_CYCLES),
  parameter logic [15:0] WAKE_BUSY_CYCLES = 16'(`RTC_WAKE_BUSY_CYCLES)
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Register port
  input  wire logic [6:0]    reg_addr_i,
  input  wire rtc_pkg::word_t reg_wdata_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  output rtc_pkg::word_t     reg_rdata_o,
  // Device side
  input  wire logic          event_capture_i,
  input  wire rtc_pkg::word_t checksum_i,
  output rtc_pkg::word_t     header_time_o,
  output rtc_pkg::word_t     header_date_o,
  output rtc_pkg::word_t     header_year_o,
  output logic               standby_o,
  output logic               busy_o
);
  import rtc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  word_t       time_q, date_q, year_q, wake_time_q, wake_date_q, flash_count_q, rdata_q;
  word_t       hdr_time_q, hdr_date_q, hdr_year_q;
  word_t       time_n, date_n, year_n;
  power_e      pwr_q;
  logic [31:0] presc_q;
  logic [15:0] busy_q;
  logic        first_done_q;
  logic        tick, wr_ok, cmd_wr, cmd_flash, first_cap, wake_hit, leap;
  logic [7:0]  last_day;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  // Access is held off while waking so a half-restored state is never seen
  assign wr_ok     = reg_wr_i && (pwr_q != PWR_WAKING);
  assign cmd_wr    = wr_ok && (reg_addr_i == `RTC_ADDR_GLOBAL_CMD);
  assign cmd_flash = cmd_wr && |(reg_wdata_i & `RTC_CMD_FLASH_MASK);
  assign first_cap = event_capture_i && !first_done_q;
  assign tick      = (presc_q == MINUTE_CYCLES - 32'h1);

  // ----------------------------------------
  // Calendar next value
  // ----------------------------------------
  always_comb
  begin
    leap = date_q[12] ? 1'b0 : 1'b0;
    leap = (year_q[4] == 1'b0) ? (year_q[3:0] == 4'h0 || year_q[3:0] == 4'h4 || year_q[3:0] == 4'h8)
                               : (year_q[3:0] == 4'h2 || year_q[3:0] == 4'h6);
    unique case (date_q[12:8])
      5'h02:                      last_day = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: last_day = 8'h30;
      default:                    last_day = 8'h31;
    endcase
    time_n = time_q;
    date_n = date_q;
    year_n = year_q;
    // Carries cascade so no digit ever leaves its decimal range
    if (time_q[6:0] != 7'h59)
      time_n[6:0] = 7'(bcd_inc({1'b0, time_q[6:0]}));
    else
    begin
      time_n[6:0] = 7'h00;
      if (time_q[13:8] != 6'h23)
        time_n[13:8] = 6'(bcd_inc({2'b00, time_q[13:8]}));
      else
      begin
        time_n[13:8] = 6'h00;
        if ({2'b00, date_q[5:0]} < last_day)
          date_n[5:0] = 6'(bcd_inc({2'b00, date_q[5:0]}));
        else
        begin
          date_n[5:0] = 6'h01;
          if (date_q[12:8] < 5'h12)
            date_n[12:8] = 5'(bcd_inc({3'b000, date_q[12:8]}));
          else
          begin
            date_n[12:8] = 5'h01;
            year_n[7:0]  = (year_q[7:0] == 8'h99) ? 8'h00 : bcd_inc(year_q[7:0]);
          end
        end
      end
    end
  end

  // Timed wake looks at the value about to be loaded on this tick
  assign wake_hit = tick && (pwr_q == PWR_STANDBY) && wake_time_q[`RTC_WAKE_EN_BIT]
                    && (time_n[13:0] == wake_time_q[13:0])
                    && ({1'b0, date_n[12:0]} == wake_date_q[13:0]);

  // ----------------------------------------
  // Minute prescaler
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      presc_q <= 32'h0;
    else if (tick || (wr_ok && reg_addr_i == `RTC_ADDR_TIME))
      presc_q <= 32'h0;
    else
      presc_q <= presc_q + 32'h1;

  // ----------------------------------------
  // Clock registers
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      time_q <= `RTC_RESET_WORD;
      date_q <= `RTC_RESET_WORD;
      year_q <= `RTC_RESET_WORD;
    end
    else
    begin
      // A host write wins over the tick for that one register
      if (wr_ok && reg_addr_i == `RTC_ADDR_TIME)
        time_q <= reg_wdata_i & `RTC_MASK_TIME;
      else if (tick)
        time_q <= time_n;
      if (wr_ok && reg_addr_i == `RTC_ADDR_DATE)
        date_q <= reg_wdata_i & `RTC_MASK_DATE;
      else if (tick)
        date_q <= date_n;
      if (wr_ok && reg_addr_i == `RTC_ADDR_YEAR)
        year_q <= reg_wdata_i & `RTC_MASK_YEAR;
      else if (tick)
        year_q <= year_n;
    end

  // Wake registers are written by the host ahead of standby
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      wake_time_q <= `RTC_RESET_WORD;
      wake_date_q <= `RTC_RESET_WORD;
    end
    else
    begin
      if (wr_ok && reg_addr_i == `RTC_ADDR_WAKE_TIME)
        wake_time_q <= reg_wdata_i & `RTC_MASK_WAKE_TIME;
      if (wr_ok && reg_addr_i == `RTC_ADDR_WAKE_DATE)
        wake_date_q <= reg_wdata_i & `RTC_MASK_WAKE_DATE;
    end

  // ----------------------------------------
  // Power state
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      pwr_q  <= PWR_RUN;
      busy_q <= 16'h0;
    end
    else
      unique case (pwr_q)
        PWR_RUN:
          if (cmd_wr && reg_wdata_i[`RTC_CMD_STANDBY_BIT] && !reg_wdata_i[`RTC_CMD_WAKE_BIT])
            pwr_q <= PWR_STANDBY;
        PWR_STANDBY:
          if (wake_hit || (cmd_wr && reg_wdata_i[`RTC_CMD_WAKE_BIT]))
          begin
            pwr_q  <= PWR_WAKING;
            busy_q <= WAKE_BUSY_CYCLES - 16'h1;
          end
        PWR_WAKING:
          if (busy_q == 16'h0)
            pwr_q <= PWR_RUN;
          else
            busy_q <= busy_q - 16'h1;
      endcase

  assign standby_o = (pwr_q == PWR_STANDBY);
  assign busy_o    = (pwr_q == PWR_WAKING);

  // ----------------------------------------
  // Flash write counter and event header
  // ----------------------------------------
  // A flash command write and the first capture in one cycle are two flash cycles
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      flash_count_q <= `RTC_RESET_WORD;
      first_done_q  <= 1'b0;
    end
    else
    begin
      flash_count_q <= flash_count_q + {15'h0, cmd_flash} + {15'h0, first_cap};
      if (event_capture_i)
        first_done_q <= 1'b1;
    end

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      hdr_time_q <= `RTC_RESET_WORD;
      hdr_date_q <= `RTC_RESET_WORD;
      hdr_year_q <= `RTC_RESET_WORD;
    end
    else if (event_capture_i)
    begin
      hdr_time_q <= time_q;
      hdr_date_q <= date_q;
      hdr_year_q <= year_q;
    end

  assign header_time_o = hdr_time_q;
  assign header_date_o = hdr_date_q;
  assign header_year_o = hdr_year_q;

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      rdata_q <= `RTC_RESET_WORD;
    else if (reg_rd_i && pwr_q != PWR_WAKING)
      unique case (reg_addr_i)
        `RTC_ADDR_FLASH_COUNT: rdata_q <= flash_count_q;
        `RTC_ADDR_CHECKSUM:   rdata_q <= checksum_i;
        `RTC_ADDR_TIME:       rdata_q <= time_q;
        `RTC_ADDR_DATE:       rdata_q <= date_q;
        `RTC_ADDR_YEAR:       rdata_q <= year_q;
        `RTC_ADDR_WAKE_TIME:  rdata_q <= wake_time_q;
        `RTC_ADDR_WAKE_DATE:  rdata_q <= wake_date_q;
        default:              rdata_q <= `RTC_RESET_WORD;
      endcase

  assign reg_rdata_o = rdata_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_time_digits: assert property (time_q[3:0] <= 4'h9 && time_q[6:4] <= 3'h5 && time_q[13:8] <= 6'h23
                                    || $past(wr_ok)) else $error("time digits out of range");
  chk_date_roll: assert property (tick && time_q[13:0] == 14'h2359 && date_q[12:0] == 13'h1231
                                  && !wr_ok |=> date_q[12:0] == 13'h0101) else $error("new year carry wrong");
  chk_header_copy: assert property (event_capture_i |=> header_time_o == $past(time_q)
                                    && header_year_o == $past(year_q)) else $error("header not copied");
  chk_wake_match: assert property (wake_hit |=> busy_o ##1 busy_o) else $error("timed wake missed");
  chk_wake_disarmed: assert property (standby_o && !wake_time_q[`RTC_WAKE_EN_BIT] && !cmd_wr
                                      |=> standby_o) else $error("wake while disarmed");
  chk_checksum_read: assert property (reg_rd_i && !busy_o && reg_addr_i == `RTC_ADDR_CHECKSUM
                                      |=> reg_rdata_o == $past(checksum_i)) else $error("checksum read wrong");
  chk_flash_event: assert property (event_capture_i && !cmd_flash
                                    |=> flash_count_q == $past(flash_count_q) + {15'h0, !$past(first_done_q)})
                                    else $error("event count wrong");
  chk_flash_cmd: assert property (cmd_flash && !event_capture_i |=> flash_count_q == $past(flash_count_q) + 16'h1)
                                  else $error("command count wrong");
  chk_standby_entry: assert property (pwr_q == PWR_RUN && cmd_wr && reg_wdata_i[`RTC_CMD_STANDBY_BIT]
                                      && !reg_wdata_i[`RTC_CMD_WAKE_BIT] |=> standby_o) else $error("no standby");
  chk_busy_hold: assert property (busy_o && busy_q != 16'h0 |=> busy_o && busy_q == $past(busy_q) - 16'h1
                                  && !wr_ok) else $error("busy window broken");
  chk_time_write: assert property (wr_ok && reg_addr_i == `RTC_ADDR_TIME
                                   |=> time_q == ($past(reg_wdata_i) & `RTC_MASK_TIME)) else $error("time not loaded");

  cov_timed_wake: cover property (wake_hit);
  cov_cmd_wake: cover property (standby_o && cmd_wr && reg_wdata_i[`RTC_CMD_WAKE_BIT]);
  cov_first_capture: cover property (first_cap);
  cov_day_roll: cover property (tick && time_q[13:0] == 14'h2359);

endmodule : rtc_calendar

//--- shared/rtc_cfg.svh
// Offsets, field masks and timing counts for the calendar clock block.
// Assumes byte addresses of the serial register port; each register is one 16-bit word.
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RTC_ADDR_FLASH_COUNT 7'h00
`define RTC_ADDR_CHECKSUM    7'h1e
`define RTC_ADDR_TIME        7'h2e
`define RTC_ADDR_DATE        7'h30
`define RTC_ADDR_YEAR        7'h32
`define RTC_ADDR_WAKE_TIME   7'h34
`define RTC_ADDR_WAKE_DATE   7'h36
`define RTC_ADDR_GLOBAL_CMD  7'h4a

// ----------------------------------------
// Field masks, bits and reset values
// ----------------------------------------
`define RTC_MASK_TIME        16'h3f7f
`define RTC_MASK_DATE        16'h1f3f
`define RTC_MASK_YEAR        16'h00ff
`define RTC_MASK_WAKE_TIME   16'hbf7f
`define RTC_MASK_WAKE_DATE   16'h3f3f
`define RTC_WAKE_EN_BIT      15
`define RTC_CMD_STANDBY_BIT  2
`define RTC_CMD_WAKE_BIT     8
`define RTC_CMD_FLASH_MASK   16'h000b
`define RTC_RESET_WORD       16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define RTC_CLK_HZ           64'd40000000
`define RTC_MINUTE_S         64'd60
`define RTC_MINUTE_CYCLES    (`RTC_MINUTE_S * `RTC_CLK_HZ)
`define RTC_WAKE_BUSY_US     64'd200
`define RTC_WAKE_BUSY_CYCLES (`RTC_WAKE_BUSY_US * `RTC_CLK_HZ / 64'd1000000)

`endif

//--- shared/rtc_pkg.sv
// Types shared by the calendar clock block.
// Assumes the constants header is included wherever offsets are needed.
package rtc_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {PWR_RUN, PWR_STANDBY, PWR_WAKING} power_e;
endpackage : rtc_pkg

//--- verification/rtc_host.sv
// Host model of the serial register port of the calendar block.
// Assumes the bench calls wr and rd by hierarchy; strobes change at falling edges.
`timescale 1ns/1ps
module rtc_host (
  // Clock
  input  wire logic           clk_i,
  // Register port
  input  wire rtc_pkg::word_t reg_rdata_i,
  output logic [6:0]          reg_addr_o,
  output rtc_pkg::word_t      reg_wdata_o,
  output logic                reg_wr_o,
  output logic                reg_rd_o
);
  import rtc_pkg::*;
  initial
  begin
    reg_addr_o = 7'h55;
    reg_wdata_o = 16'ha5a5;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // Released lines show the inverse so a stale value never looks valid
  task automatic wr(input logic [6:0] a, input word_t d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, output word_t d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask : rd
endmodule : rtc_host

//--- verification/tb.sv
// Self-checking bench for the calendar block, host model on the register port.
// Assumes short minute and wake counts set by parameter.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb;
  import rtc_pkg::*;
  logic       clk_i, rst_i, reg_wr, reg_rd, event_capture, standby, busy;
  logic [6:0] reg_addr;
  word_t      reg_wdata, reg_rdata, checksum, hdr_t, hdr_d, hdr_y, f;
  int         miscompares, samples_checked, cycles, seed, i, k, n;
  word_t      cmds[5] = '{16'h0001, 16'h0002, 16'h0008, 16'h000b, 16'h0010};
  word_t      yr_in[6] = '{16'h0099, 16'h0023, 16'h0024, 16'h0024, 16'h0024, 16'h0050};
  word_t      dt_in[6] = '{16'h1231, 16'h0228, 16'h0228, 16'h0430, 16'h0131, 16'h0615};
  word_t      dt_ex[6] = '{16'h0101, 16'h0301, 16'h0229, 16'h0501, 16'h0201, 16'h0615};
  word_t      yr_ex[6] = '{16'h0000, 16'h0023, 16'h0024, 16'h0024, 16'h0024, 16'h0050};
  rtc_calendar #(.MINUTE_CYCLES(32'd20), .WAKE_BUSY_CYCLES(16'd4)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .event_capture_i(event_capture), .checksum_i(checksum), .header_time_o(hdr_t),
    .header_date_o(hdr_d), .header_year_o(hdr_y), .standby_o(standby), .busy_o(busy));
  rtc_host host (.clk_i(clk_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic word_t mk_time(int m);
    m = m % 1440;
    return {2'b00, 2'(m / 600), 4'((m / 60) % 10), 1'b0, 3'((m % 60) / 10), 4'(m % 10)};
  endfunction : mk_time
  task automatic chk_rd(input logic [6:0] a, input word_t e);
    word_t d;
    host.rd(a, d);
    `CHK(d, e)
  endtask : chk_rd
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Ceiling well above the several hundred cycles the sequence needs
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles > 8000)
    begin
      miscompares++;
      conclude();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    seed = 32'hfb367fc3;
    rst_i = 1'b1;
    event_capture = 1'b0;
    checksum = 16'h0000;
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    chk_rd(7'h30, 16'h0000);
    chk_rd(7'h32, 16'h0000);
    chk_rd(7'h34, 16'h0000);
    chk_rd(7'h36, 16'h0000);
    chk_rd(7'h2e, 16'h0000);
    chk_rd(7'h4a, 16'h0000);
    host.wr(7'h34, 16'hffff);
    chk_rd(7'h34, 16'hbf7f);
    host.wr(7'h36, 16'hffff);
    chk_rd(7'h36, 16'h3f3f);
    for (i = 0; i < 4; i++)
    begin
      checksum = word_t'($random(seed));
      host.wr(7'h1e, ~checksum);
      chk_rd(7'h1e, checksum);
    end
    // Masked load, then header copies on event capture
    host.rd(7'h00, f);
    host.wr(7'h32, 16'hff24);
    host.wr(7'h30, 16'he2d9);
    host.wr(7'h2e, 16'he2b1);
    for (k = 0; k < 2; k++)
    begin
      @(negedge clk_i);
      event_capture = 1'b1;
      @(negedge clk_i);
      event_capture = 1'b0;
      `CHK(hdr_t, 16'h2231)
      `CHK(hdr_d, 16'h0219)
      `CHK(hdr_y, 16'h0024)
      chk_rd(7'h00, word_t'(f + 16'h0001));
    end
    chk_rd(7'h2e, 16'h2231);
    for (i = 0; i < 5; i++)
    begin
      host.rd(7'h00, f);
      host.wr(7'h00, ~f);
      host.wr(7'h4a, cmds[i]);
      chk_rd(7'h00, word_t'(f + 16'(((cmds[i] & 16'h000b) != 0))));
    end
    // Minute carries: table corners, then random times of day
    for (i = 0; i < 12; i++)
    begin
      k = (i < 5) ? i : 5;
      n = (i < 5) ? 1439 : {$random(seed)} % 1439;
      host.wr(7'h32, yr_in[k]);
      host.wr(7'h30, dt_in[k]);
      host.wr(7'h2e, mk_time(n));
      repeat (22) @(negedge clk_i);
      chk_rd(7'h2e, mk_time(n + 1));
      chk_rd(7'h30, dt_ex[k]);
      chk_rd(7'h32, yr_ex[k]);
    end
    // Timed wake from standby, access refused while waking
    host.wr(7'h30, 16'h0615);
    host.wr(7'h2e, 16'h1015);
    host.wr(7'h34, 16'h9016);
    host.wr(7'h36, 16'h0615);
    host.wr(7'h4a, 16'h0004);
    `CHK(standby, 1'b1)
    for (n = 0; n < 60 && busy !== 1'b1; n++) @(negedge clk_i);
    `CHK(busy, 1'b1)
    host.wr(7'h30, 16'h0101);
    for (n = 0; n < 20 && busy !== 1'b0; n++) @(negedge clk_i);
    `CHK(standby, 1'b0)
    chk_rd(7'h30, 16'h0615);
    // Disabled timed wake, then command wake
    host.wr(7'h34, 16'h1017);
    host.wr(7'h4a, 16'h0004);
    repeat (30) @(negedge clk_i);
    `CHK({standby, busy}, 2'b10)
    host.wr(7'h4a, 16'h0100);
    for (n = 0; n < 20 && busy === 1'b1; n++) @(negedge clk_i);
    `CHK(n, 4)
    `CHK(standby, 1'b0)
    conclude();
  end
endmodule : tb
